// ==== hw/radio_seq_pkg.sv ====
package radio_seq_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int STEP_SHORT_NS = 64000;
    localparam int STEP_MID_NS = 4100000;
    localparam int STEP_LONG_NS = 262000000;
    localparam int STEP_SHORT_CYC = STEP_SHORT_NS / CLK_PERIOD_NS;
    localparam int STEP_MID_CYC = STEP_MID_NS / CLK_PERIOD_NS;
    localparam int STEP_LONG_CYC = STEP_LONG_NS / CLK_PERIOD_NS;
    localparam int CYC_W = 23;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_TIMER = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam int LAUNCH_BIT = 0;
    localparam int STOP_BIT = 1;
    localparam int CFG_W = 15;
    localparam int TIMER_W = 20;
    localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;
    localparam logic [TIMER_W-1:0] TIMER_RST = 20'h00000;

    typedef enum logic [2:0] {
        SEQ_OFF = 3'b000,
        SEQ_IDLE = 3'b001,
        SEQ_TX = 3'b011,
        SEQ_RX = 3'b010,
        SEQ_HELD = 3'b110,
        SEQ_WAIT_THR = 3'b111,
        SEQ_SYNTH = 3'b101
    } seq_state_t;

    typedef enum logic [2:0] {
        MODE_SLEEP = 3'h0,
        MODE_STANDBY = 3'h1,
        MODE_SYNTH = 3'h2,
        MODE_TX = 3'h3,
        MODE_RX = 3'h4
    } chip_mode_t;
    localparam chip_mode_t MODE_RST = MODE_STANDBY;

    // Bit 0 is idleSleepSelect, bit 14 badChecksumAutodiscard
    typedef struct packed {
        logic badChecksumAutodiscard;
        logic [2:0] frameHeldExitSelect;
        logic [1:0] rxTimeoutExitSelect;
        logic [2:0] receiveExitSelect;
        logic transmitExitSelect;
        logic idleExitSelect;
        logic lowPowerChoice;
        logic [1:0] startExitSelect;
        logic idleSleepSelect;
    } seq_cfg_t;

    typedef struct packed {
        logic [7:0] secondTimerMultiplier;
        logic [7:0] firstTimerMultiplier;
        logic [1:0] secondTimerStep;
        logic [1:0] firstTimerStep;
    } timer_cfg_t;

    localparam int EVT_N = 11;
    typedef struct packed {
        logic txFrameDone;
        logic rxPayloadComplete;
        logic checksumPassEvent;
        logic signalLevelEvent;
        logic syncMatchEvent;
        logic preambleFoundEvent;
        logic queueDrainedEvent;
        logic queueThresholdEvent;
        logic levelWaitExpired;
        logic preambleWaitExpired;
        logic syncWaitExpired;
    } radio_events_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage

// ==== hw/event_edge.sv ====
module event_edge
    import radio_seq_pkg::*;
#(
    parameter int WIDTH = EVT_N
) (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [WIDTH-1:0] levels, // Event sources, same clock
    output logic [WIDTH-1:0] rises // One-cycle pulse per rising edge
);
    typedef struct packed {
        logic [WIDTH-1:0] prev_r;
    } edge_state_t;

    edge_state_t s, n;

    always_comb begin
        n = s;
        n.prev_r = levels;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Sources are levels that may stay high; only the edge counts as an event
    for (genvar i = 0; i < WIDTH; i++) begin : g_rise
        assign rises[i] = levels[i] & ~s.prev_r[i];
    end
endmodule // event_edge

// ==== hw/interval_timer.sv ====
module interval_timer
    import radio_seq_pkg::*;
#(
    parameter int CYC_SHORT = STEP_SHORT_CYC,
    parameter int CYC_MID = STEP_MID_CYC,
    parameter int CYC_LONG = STEP_LONG_CYC
) (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic run, // Count while high
    input wire logic restart, // Start a fresh interval
    input wire logic [1:0] stepSel, // Step size code, 0 disables
    input wire logic [7:0] multiplier, // Steps per interval, 0 disables
    output logic fire // One-cycle pulse at interval end
);
    typedef struct packed {
        logic [CYC_W-1:0] cycCnt;
        logic [7:0] unitCnt;
        logic fire;
    } timer_state_t;

    timer_state_t s, n;

    function automatic logic [CYC_W-1:0] stepLast(input logic [1:0] sel);
        case (sel)
            2'h1: stepLast = CYC_W'(CYC_SHORT - 1);
            2'h2: stepLast = CYC_W'(CYC_MID - 1);
            default: stepLast = CYC_W'(CYC_LONG - 1);
        endcase
    endfunction

    always_comb begin
        n = s;
        n.fire = 1'b0;
        if (restart || !run) begin
            n.cycCnt = '0;
            n.unitCnt = '0;
        end else if (stepSel != 2'h0 && multiplier != 8'h00) begin
            if (s.cycCnt >= stepLast(stepSel)) begin
                n.cycCnt = '0;
                if (s.unitCnt >= multiplier - 8'h01) begin
                    n.unitCnt = '0;
                    n.fire = 1'b1;
                end else begin
                    n.unitCnt = s.unitCnt + 8'h01;
                end
            end else begin
                n.cycCnt = s.cycCnt + CYC_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign fire = s.fire;
endmodule // interval_timer

// ==== hw/radio_mode_sequencer.sv ====
// Contract
// - Idle on first timer: Transmit or Receive
// - Transmit done: low-power selection or Receive
// - Payload complete: held (001), low-power (010)
// - 011: checksum pass holds; fail means timeout unless badChecksumAutodiscard is set
// - 100/101/110: off on level/sync/preamble
// - Second timer in Receive: low-power selection
// - Rx timeout selector picks restart/Tx/low-power/off
// - Any of three wait expiries is timeout
// - Held: off, Tx on drained, low-power
// - Held 011 via synth mode, 100 direct
// - First timer after second or launch
// - Second timer fires after first timer
// - Step codes: off, 64us, 4.1ms, 262ms
// - Timer chain ignores sequencer state, except that it halts while off
// - Stop forces off at once
// - Launch only from Sleep or Standby
// - Start selector picks the first step
// - Low-power choice: off+initial mode, or Idle
// - Idle: Standby if 0, Sleep if 1
//
// The APB register port and the register offsets were left to the implementer.
module radio_mode_sequencer
    import radio_seq_pkg::*;
#(
    parameter int STEP_MID_CYCLES = STEP_MID_CYC,
    parameter int STEP_LONG_CYCLES = STEP_LONG_CYC
) (
    input wire logic ref_clk, // 25 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire apb_req_t apbReq, // APB request signals
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire radio_events_t events, // Packet engine event levels
    input wire chip_mode_t radioModeIn, // Present chip mode
    output chip_mode_t modeCmd, // Commanded chip mode
    output logic modeCmdStrobe, // Pulse with each mode command
    output logic receiverRestartCmd, // Pulse to restart reception
    output logic seqActive // Sequencer not off
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        seq_state_t state;
        chip_mode_t modeCmd;
        chip_mode_t initialMode;
        logic phase;
        logic modeStrobe;
        logic restartPulse;
        seq_cfg_t cfg;
        timer_cfg_t tcfg;
        logic [31:0] prdata;
    } seq_regs_t;

    seq_regs_t s, n;
    radio_events_t rise;
    logic t1Fire;
    logic t2Fire;
    logic setup;
    logic access;
    logic wrCtrl;
    logic stopWr;
    logic launch;
    logic rx_wait_expired;
    logic goLp;
    logic toInitial;
    logic moved;
    logic restartRx;
    seq_state_t nxtSt;

    function automatic chip_mode_t stateMode(input seq_state_t st, input seq_cfg_t c,
                                             input chip_mode_t init);
        case (st)
            SEQ_IDLE: stateMode = c.idleSleepSelect ? MODE_SLEEP : MODE_STANDBY;
            SEQ_TX: stateMode = MODE_TX;
            SEQ_RX: stateMode = MODE_RX;
            SEQ_HELD: stateMode = MODE_RX;
            SEQ_SYNTH: stateMode = MODE_SYNTH;
            default: stateMode = init;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADDR_CTRL) || (a == ADDR_CFG) || (a == ADDR_TIMER)
            || (a == ADDR_STATUS);
    endfunction

    // ------------------------------------------------------------
    // Event edges and timers
    // ------------------------------------------------------------
    event_edge #(
        .WIDTH(EVT_N)
    ) u_edges (
        .ref_clk(ref_clk),
        .rst(rst),
        .levels(events),
        .rises(rise)
    );

    // Chain runs in every active state, so a single enabled timer stalls it
    interval_timer #(
        .CYC_SHORT(STEP_SHORT_CYC),
        .CYC_MID(STEP_MID_CYCLES),
        .CYC_LONG(STEP_LONG_CYCLES)
    ) u_first (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(s.state != SEQ_OFF && !s.phase),
        .restart(launch || t2Fire),
        .stepSel(s.tcfg.firstTimerStep),
        .multiplier(s.tcfg.firstTimerMultiplier),
        .fire(t1Fire)
    );

    interval_timer #(
        .CYC_SHORT(STEP_SHORT_CYC),
        .CYC_MID(STEP_MID_CYCLES),
        .CYC_LONG(STEP_LONG_CYCLES)
    ) u_second (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(s.state != SEQ_OFF && s.phase),
        .restart(t1Fire),
        .stepSel(s.tcfg.secondTimerStep),
        .multiplier(s.tcfg.secondTimerMultiplier),
        .fire(t2Fire)
    );

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign setup = apbReq.psel && !apbReq.penable;
    assign access = apbReq.psel && apbReq.penable;
    assign wrCtrl = access && apbReq.pwrite && apbReq.paddr == ADDR_CTRL;
    assign stopWr = wrCtrl && apbReq.pwdata[STOP_BIT];
    // Stop wins when both bits are written together
    assign launch = wrCtrl && apbReq.pwdata[LAUNCH_BIT] && !apbReq.pwdata[STOP_BIT]
        && s.state == SEQ_OFF
        && (radioModeIn == MODE_SLEEP || radioModeIn == MODE_STANDBY);
    assign rx_wait_expired = rise.levelWaitExpired || rise.preambleWaitExpired
        || rise.syncWaitExpired
        || (s.cfg.receiveExitSelect == 3'b011 && rise.rxPayloadComplete
            && !events.checksumPassEvent && !s.cfg.badChecksumAutodiscard);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxtSt = s.state;
        goLp = 1'b0;
        restartRx = 1'b0;
        case (s.state)
            SEQ_OFF: begin
                if (launch) begin
                    case (s.cfg.startExitSelect)
                        2'b00: goLp = 1'b1;
                        2'b01: nxtSt = SEQ_RX;
                        2'b10: nxtSt = SEQ_TX;
                        default: nxtSt = SEQ_WAIT_THR;
                    endcase
                end
            end
            SEQ_IDLE: begin
                if (t1Fire) begin
                    nxtSt = s.cfg.idleExitSelect ? SEQ_RX : SEQ_TX;
                end
            end
            SEQ_TX: begin
                if (rise.txFrameDone) begin
                    if (s.cfg.transmitExitSelect) begin
                        nxtSt = SEQ_RX;
                    end else begin
                        goLp = 1'b1;
                    end
                end
            end
            SEQ_RX: begin
                if (t2Fire) begin
                    goLp = 1'b1;
                end else if (rx_wait_expired) begin
                    case (s.cfg.rxTimeoutExitSelect)
                        2'b00: restartRx = 1'b1;
                        2'b01: nxtSt = SEQ_TX;
                        2'b10: goLp = 1'b1;
                        default: nxtSt = SEQ_OFF;
                    endcase
                end else begin
                    case (s.cfg.receiveExitSelect)
                        3'b001: begin
                            if (rise.rxPayloadComplete) begin
                                nxtSt = SEQ_HELD;
                            end
                        end
                        3'b010: goLp = rise.rxPayloadComplete;
                        3'b011: begin
                            if (rise.checksumPassEvent) begin
                                nxtSt = SEQ_HELD;
                            end
                        end
                        3'b100: begin
                            if (rise.signalLevelEvent) begin
                                nxtSt = SEQ_OFF;
                            end
                        end
                        3'b101: begin
                            if (rise.syncMatchEvent) begin
                                nxtSt = SEQ_OFF;
                            end
                        end
                        3'b110: begin
                            if (rise.preambleFoundEvent) begin
                                nxtSt = SEQ_OFF;
                            end
                        end
                        default: nxtSt = s.state;
                    endcase
                end
            end
            SEQ_HELD: begin
                case (s.cfg.frameHeldExitSelect)
                    3'b000: nxtSt = SEQ_OFF;
                    3'b001: begin
                        if (rise.queueDrainedEvent) begin
                            nxtSt = SEQ_TX;
                        end
                    end
                    3'b010: goLp = 1'b1;
                    3'b011: nxtSt = SEQ_SYNTH;
                    3'b100: nxtSt = SEQ_RX;
                    default: nxtSt = s.state;
                endcase
            end
            SEQ_SYNTH: nxtSt = SEQ_RX;
            SEQ_WAIT_THR: begin
                if (rise.queueThresholdEvent) begin
                    nxtSt = SEQ_TX;
                end
            end
            default: nxtSt = SEQ_OFF;
        endcase
        // Low-power selection never rests, it is folded into this cycle
        toInitial = goLp && !s.cfg.lowPowerChoice;
        if (goLp) begin
            nxtSt = s.cfg.lowPowerChoice ? SEQ_IDLE : SEQ_OFF;
        end
        if (stopWr) begin
            nxtSt = SEQ_OFF;
            toInitial = 1'b0;
            restartRx = 1'b0;
        end
        moved = nxtSt != s.state;
    end

    always_comb begin
        n = s;
        n.modeStrobe = 1'b0;
        n.restartPulse = restartRx;
        n.state = nxtSt;
        if (launch) begin
            n.initialMode = radioModeIn;
            n.phase = 1'b0;
        end else if (t1Fire) begin
            n.phase = 1'b1;
        end else if (t2Fire) begin
            n.phase = 1'b0;
        end
        if (moved || restartRx || toInitial) begin
            n.modeStrobe = 1'b1;
            if (nxtSt != SEQ_OFF) begin
                n.modeCmd = stateMode(nxtSt, s.cfg, s.initialMode);
            end else if (toInitial) begin
                n.modeCmd = launch ? radioModeIn : s.initialMode;
            end
        end
        if (access && apbReq.pwrite && apbReq.paddr == ADDR_CFG) begin
            n.cfg = seq_cfg_t'(apbReq.pwdata[CFG_W-1:0]);
        end
        if (access && apbReq.pwrite && apbReq.paddr == ADDR_TIMER) begin
            n.tcfg = timer_cfg_t'(apbReq.pwdata[TIMER_W-1:0]);
        end
        // Read data is captured in setup so it stands from flops in access
        if (setup) begin
            case (apbReq.paddr)
                ADDR_CFG: n.prdata = {17'h00000, s.cfg};
                ADDR_TIMER: n.prdata = {12'h000, s.tcfg};
                ADDR_STATUS: n.prdata = {21'h000000, s.state != SEQ_OFF, s.phase,
                                         s.initialMode, s.modeCmd, s.state};
                default: n.prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s.state <= SEQ_OFF;
            s.modeCmd <= MODE_RST;
            s.initialMode <= MODE_RST;
            s.phase <= 1'b0;
            s.modeStrobe <= 1'b0;
            s.restartPulse <= 1'b0;
            s.cfg <= seq_cfg_t'(CFG_RST);
            s.tcfg <= timer_cfg_t'(TIMER_RST);
            s.prdata <= 32'h00000000;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = access && !mapped(apbReq.paddr);
    assign modeCmd = s.modeCmd;
    assign modeCmdStrobe = s.modeStrobe;
    assign receiverRestartCmd = s.restartPulse;
    assign seqActive = s.state != SEQ_OFF;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    stop_forces_off_a: assert property (stopWr |=> s.state == SEQ_OFF)
        else $error("stop did not force the sequencer off");
    idle_exit_a: assert property (
        s.state == SEQ_IDLE && t1Fire && !stopWr
        |=> s.state == ($past(s.cfg.idleExitSelect) ? SEQ_RX : SEQ_TX)
    ) else $error("idle exit went to the wrong state");
    tx_exit_a: assert property (
        s.state == SEQ_TX && rise.txFrameDone && s.cfg.transmitExitSelect && !stopWr
        |=> s.state == SEQ_RX ##0 modeCmdStrobe && modeCmd == MODE_RX
    ) else $error("transmit exit to receive failed");
    rx_t2_exit_a: assert property (
        s.state == SEQ_RX && t2Fire && !stopWr |=> s.state inside {SEQ_IDLE, SEQ_OFF}
    ) else $error("second timer did not leave receive");
    rx_held_a: assert property (
        s.state == SEQ_RX && s.cfg.receiveExitSelect == 3'b001 && rise.rxPayloadComplete
        && !t2Fire && !rx_wait_expired && !stopWr |=> s.state == SEQ_HELD
    ) else $error("payload complete did not reach frame held");
    rx_unused_a: assert property (
        s.state == SEQ_RX && s.cfg.receiveExitSelect inside {3'b000, 3'b111}
        && !t2Fire && !rx_wait_expired && !stopWr |=> s.state == SEQ_RX
    ) else $error("unused receive selector caused an exit");
    rx_restart_a: assert property (
        s.state == SEQ_RX && rx_wait_expired && !t2Fire && !stopWr
        && s.cfg.rxTimeoutExitSelect == 2'b00
        |=> receiverRestartCmd && s.state == SEQ_RX ##1 !receiverRestartCmd
    ) else $error("rx timeout restart not issued");
    held_synth_a: assert property (
        s.state == SEQ_HELD && s.cfg.frameHeldExitSelect == 3'b011 && !stopWr
        |=> modeCmd == MODE_SYNTH ##1 s.state inside {SEQ_RX, SEQ_OFF}
    ) else $error("frame held did not pass through synth mode");
    timer_phase_a: assert property (t1Fire |=> s.phase && !t1Fire)
        else $error("first timer event did not hand over to the second");
    launch_rx_a: assert property (
        launch && s.cfg.startExitSelect == 2'b01 |=> s.state == SEQ_RX [*1] ##0 seqActive
    ) else $error("launch with start code 01 did not enter receive");

    launch_c: cover property (launch);
    idle_to_tx_c: cover property (s.state == SEQ_IDLE ##1 s.state == SEQ_TX);
    rx_to_held_c: cover property (s.state == SEQ_RX ##1 s.state == SEQ_HELD);
    timer_cycle_c: cover property (s.phase ##1 t2Fire);
endmodule // radio_mode_sequencer

// ==== tb/radio_partner.sv ====
module radio_partner
    import radio_seq_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset
    input wire chip_mode_t modeCmd, // Commanded mode
    input wire logic modeCmdStrobe, // Command pulse
    input wire logic toStandby, // Host puts chip in Standby
    input wire logic [EVT_N-1:0] raise, // Wanted event levels
    output chip_mode_t radioModeIn, // Present chip mode
    output radio_events_t events // Event levels
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Mode controller and event sources
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        events <= raise;
        if (rst || toStandby) begin
            radioModeIn <= MODE_STANDBY;
        end else if (modeCmdStrobe) begin
            radioModeIn <= modeCmd;
        end
    end
endmodule // radio_partner

// ==== tb/radio_mode_sequencer_tb.sv ====
module radio_mode_sequencer_tb
    import radio_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    apb_req_t apbReq = '0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic modeCmdStrobe;
    logic receiverRestartCmd;
    logic seqActive;
    logic toStandby = 1'b0;
    logic [EVT_N-1:0] raise = '0;
    chip_mode_t modeCmd;
    chip_mode_t radioModeIn;
    radio_events_t events;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    int restarts = 0;
    // Fields: cfg, first event, second event (15 = none), resting state
    localparam logic [25:0] TBL [22] = '{
        {15'h2842, 4'h9, 4'hf, 3'h6}, {15'h008a, 4'h9, 4'hf, 3'h1}, {15'h0102, 4'h7, 4'hf, 3'h0},
        {15'h0142, 4'h6, 4'hf, 3'h0}, {15'h0182, 4'h5, 4'hf, 3'h0}, {15'h0002, 4'h9, 4'hf, 3'h2},
        {15'h01c2, 4'h7, 4'hf, 3'h2}, {15'h28c2, 4'h8, 4'hf, 3'h6}, {15'h06c2, 4'h9, 4'hf, 3'h0},
        {15'h0202, 4'h2, 4'hf, 3'h3}, {15'h040a, 4'h1, 4'hf, 3'h1}, {15'h0602, 4'h0, 4'hf, 3'h0},
        {15'h0002, 4'h2, 4'hf, 3'h2}, {15'h0024, 4'ha, 4'hf, 3'h2}, {15'h000c, 4'ha, 4'hf, 3'h1},
        {15'h0006, 4'h3, 4'hf, 3'h3}, {15'h0842, 4'h9, 4'h4, 3'h3}, {15'h2042, 4'h9, 4'hf, 3'h2},
        {15'h1842, 4'h9, 4'hf, 3'h2}, {15'h0042, 4'h9, 4'hf, 3'h0}, {15'h0000, 4'hf, 4'hf, 3'h0},
        {15'h104a, 4'h9, 4'hf, 3'h1}};

    always #20 ref_clk = ~ref_clk;

    radio_mode_sequencer #(.STEP_MID_CYCLES(20), .STEP_LONG_CYCLES(40)) uut (.ref_clk(ref_clk),
        .rst(rst), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .events(events), .radioModeIn(radioModeIn), .modeCmd(modeCmd),
        .modeCmdStrobe(modeCmdStrobe), .receiverRestartCmd(receiverRestartCmd),
        .seqActive(seqActive));

    radio_partner far (.ref_clk(ref_clk), .rst(rst), .modeCmd(modeCmd),
        .modeCmdStrobe(modeCmdStrobe), .toStandby(toStandby), .raise(raise),
        .radioModeIn(radioModeIn), .events(events));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task summarize;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, generous against the timer scenario length
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (receiverRestartCmd === 1'b1) begin
            restarts <= restarts + 1;
        end
        if (cyc == 20000) begin
            mismatches++;
            summarize;
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        // Only the hang guard ends a stalled access
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apbReq <= '0;
    endtask

    task stat(input logic [2:0] st);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(32'(rd[2:0]), 32'(st));
        check(32'(seqActive), 32'(st != SEQ_OFF));
    endtask

    task evt(input int i);
        if (i < EVT_N) begin
            raise[i] <= 1'b1;
            repeat (2) @(posedge ref_clk);
            raise <= '0;
            repeat (4) @(posedge ref_clk);
        end
    endtask

    // Stop, back to Standby, configure, launch, fire events, read state
    task run(input logic [25:0] r);
        toStandby <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h2);
        apb(1'b1, ADDR_CFG, 32'(r[25:11]));
        toStandby <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h1);
        evt(int'(r[10:7]));
        evt(int'(r[6:3]));
        repeat (4) @(posedge ref_clk);
        stat(r[2:0]);
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, ADDR_CFG, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, ADDR_TIMER, 32'h0);
        check(rd, 32'h0);
        stat(SEQ_OFF);
        check(32'(modeCmd), 32'(MODE_STANDBY));
        apb(1'b0, 8'h10, 32'h0);
        check(32'(err), 32'h1);
        apb(1'b1, ADDR_CFG, 32'hffffffff);
        apb(1'b0, ADDR_CFG, 32'h0);
        check(rd, 32'h7fff);
        for (int k = 0; k < 22; k++) begin
            run(TBL[k]);
        end
        // Only the level-wait row with restart code 00 pulses a restart
        check(32'(restarts), 32'h1);
        // Chip left in Receive, so a fresh launch must be ignored
        run({15'h0002, 4'hf, 4'hf, 3'h2});
        apb(1'b1, ADDR_CTRL, 32'h2);
        apb(1'b1, ADDR_CTRL, 32'h1);
        stat(SEQ_OFF);
        apb(1'b1, ADDR_TIMER, 32'h01015);
        run({15'h0019, 4'hf, 4'hf, 3'h1});
        check(32'(modeCmd), 32'(MODE_SLEEP));
        repeat (1570) @(posedge ref_clk);
        stat(SEQ_IDLE);
        repeat (30) @(posedge ref_clk);
        stat(SEQ_RX);
        repeat (1595) @(posedge ref_clk);
        stat(SEQ_IDLE);
        summarize;
    end
endmodule // radio_mode_sequencer_tb
